// ---- verilog/fat_pkg.sv ----
// Constants, codes and types shared by the acquisition trigger control block
package fat_pkg;
  // ----------------------------------------------------------------
  // Widths and timing
  // ----------------------------------------------------------------
  localparam int CNT_W = 24;
  localparam int FILT_W = 8;
  localparam int CLK_PERIOD_NS = 40;
  localparam int MIN_PULSE_NS = 1000;
  // Least width rounds up to whole cycles
  localparam int WIRED_MIN_CYC = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LINK_MIN_CYC = 1;
  localparam logic [CNT_W-1:0] READOUT_CYCLES = 24'h000400;
  localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_MAX = 24'hFFFFFF;
  localparam logic [FILT_W-1:0] FILT_ZERO = 8'h00;
  localparam logic [FILT_W-1:0] FILT_ONE = 8'h01;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [1:0] KIND_EXPOSURE_START = 2'h0;
  localparam logic STYLE_PRESET = 1'b0;
  localparam logic STYLE_PULSE = 1'b1;
  localparam logic POL_RISING = 1'b1;

  typedef enum logic [1:0] {
    ORIG_HOST = 2'h0,
    ORIG_LINK = 2'h1,
    ORIG_WIRED = 2'h2
  } fat_origin_t;

  typedef enum logic [1:0] {
    ST_WAIT = 2'h0,
    ST_EXPOSE = 2'h1,
    ST_READOUT = 2'h2
  } fat_state_t;
endpackage : fat_pkg

// ---- verilog/fat_edge_if.sv ----
// Interface between the trigger controller and one trigger input conditioner
`timescale 1ns/1ps
`default_nettype none
interface fat_edge_if;
  logic pinLevel;
  logic risingActive;
  logic startPulse;
  logic endPulse;

  modport cond (input pinLevel, input risingActive, output startPulse, output endPulse);
  modport ctrl (output pinLevel, output risingActive, input startPulse, input endPulse);
endinterface : fat_edge_if
`default_nettype wire

// ---- verilog/fat_edge_cond.sv ----
// Trigger input conditioner: synchroniser, width filter and edge detector
`timescale 1ns/1ps
`default_nettype none
module fat_edge_cond #(
  parameter int MIN_CYC = 1
) (
  input wire logic clk,
  input wire logic rstSync_n,
  fat_edge_if.cond edge_io
);
  localparam logic [fat_pkg::FILT_W-1:0] RUN_LAST = fat_pkg::FILT_W'(MIN_CYC - 1);

  logic sync1_r;
  logic sync2_r;
  logic filt_r;
  logic [fat_pkg::FILT_W-1:0] runCnt_r;
  logic start_r;
  logic end_r;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Level differs from the accepted one; adopt once stable long enough
  wire differ = sync2_r ^ filt_r;
  wire adopt = differ && (runCnt_r == RUN_LAST);
  wire goesActive = adopt && (sync2_r == edge_io.risingActive);

  // Two-stage synchroniser on the pin
  always_ff @(posedge clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end
    else
    begin
      sync1_r <= edge_io.pinLevel;
      sync2_r <= sync1_r;
    end
  end

  // Width filter: short pulses never reach the filtered level
  always_ff @(posedge clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      runCnt_r <= fat_pkg::FILT_ZERO;
      filt_r <= 1'b0;
    end
    else
    begin
      runCnt_r <= (differ && !adopt) ? runCnt_r + fat_pkg::FILT_ONE : fat_pkg::FILT_ZERO;
      if (adopt)
        filt_r <= sync2_r;
    end
  end

  // One-cycle pulses on active and opposite edges
  always_ff @(posedge clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      start_r <= 1'b0;
      end_r <= 1'b0;
    end
    else
    begin
      start_r <= goesActive;
      end_r <= adopt && !goesActive;
    end
  end

  assign edge_io.startPulse = start_r;
  assign edge_io.endPulse = end_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_filterWidth;
    @(posedge clk) disable iff (!rstSync_n)
    $changed(filt_r) |-> ($past(runCnt_r) == RUN_LAST);
  endproperty
  a_filterWidth: assert property (p_filterWidth) else $error("level adopted too early");

  property p_singlePulse;
    @(posedge clk) disable iff (!rstSync_n)
    start_r |=> !start_r;
  endproperty
  a_singlePulse: assert property (p_singlePulse) else $error("start pulse longer than one cycle");
endmodule : fat_edge_cond
`default_nettype wire

// ---- verilog/fat_trigger_ctrl.sv ----
// Frame acquisition arm/disarm and exposure-start trigger control
`timescale 1ns/1ps
`default_nettype none
// Operation
// - No capture before an arm command
// - Arm persists across any number of frames
// - Disarm while idle takes effect at once
// - Disarm mid-frame waits until frame completes
// - Disarmed device ignores all exposure triggers
// - Trigger leaves waiting state, exposes, reads out
// - One frame per accepted trigger
// - Gate off: triggers generated internally
// - Internal rate follows configured frame period
// - Gate on: triggers outside waiting discarded
// - One origin selected; each fire counts once
// - Link origin takes master channel triggers
// - Wired origin: valid pulse is one trigger
// - Link/wired offer preset or pulse-length exposure
// - Preset style exposes for duration value
// - Pulse style: exposure follows trigger width
// - Only exposure-start trigger kind begins capture
// - Edge polarity selects rising or falling
// - Wired pulses under one microsecond ignored
// - Free-run rate clamped to maximum rate
module fat_trigger_ctrl (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic captureArmCmd,
  input wire logic captureDisarmCmd,
  input wire logic hostFireCmd,
  input wire logic startGateSelect,
  input wire logic [1:0] startOriginSelect,
  input wire logic [1:0] triggerKindSelect,
  input wire logic shutterTimingStyle,
  input wire logic edgePolaritySelect,
  input wire logic [23:0] shutterDurationValue,
  input wire logic [23:0] freeRunPeriodValue,
  input wire logic [23:0] minFramePeriodValue,
  input wire logic linkTriggerIn,
  input wire logic wiredTriggerIn,
  output logic captureArmed,
  output logic waitingForTrigger,
  output logic exposureActive,
  output logic readoutActive,
  output logic frameStart,
  output logic frameDone,
  output logic triggerDiscard
);
  localparam int W = fat_pkg::CNT_W;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rstMeta_r;
  logic rstSync_r;

  // Asynchronous assert, synchronous release through two stages
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end
    else
    begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end

  // ----------------------------------------------------------------
  // Trigger input conditioners
  // ----------------------------------------------------------------
  fat_edge_if linkIo ();
  fat_edge_if wiredIo ();

  assign linkIo.pinLevel = linkTriggerIn;
  assign linkIo.risingActive = (edgePolaritySelect == fat_pkg::POL_RISING);
  assign wiredIo.pinLevel = wiredTriggerIn;
  assign wiredIo.risingActive = (edgePolaritySelect == fat_pkg::POL_RISING);

  // Link input: no width filter, master channel trigger
  fat_edge_cond #(
    .MIN_CYC(fat_pkg::LINK_MIN_CYC)
  ) u_linkCond (
    .clk(clk),
    .rstSync_n(rstSync_r),
    .edge_io(linkIo.cond)
  );

  // Wired input: pulses under the least width are dropped
  fat_edge_cond #(
    .MIN_CYC(fat_pkg::WIRED_MIN_CYC)
  ) u_wiredCond (
    .clk(clk),
    .rstSync_n(rstSync_r),
    .edge_io(wiredIo.cond)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  fat_pkg::fat_state_t state_r;
  fat_pkg::fat_state_t stateNxt;
  logic armed_r;
  logic armedNxt;
  logic disarmPend_r;
  logic disarmPendNxt;
  logic pulseMode_r;
  logic [W-1:0] phaseCnt_r;
  logic [W-1:0] phaseCntNxt;
  logic [W-1:0] sinceStart_r;
  logic [W-1:0] durLatch_r;
  logic [W-1:0] expLen_r;
  logic waitOut_r;
  logic exposeOut_r;
  logic readOut_r;
  logic startOut_r;
  logic doneOut_r;
  logic discardOut_r;

  // ----------------------------------------------------------------
  // Trigger selection and acceptance
  // ----------------------------------------------------------------
  // Selected origin's start and end events
  wire originHost = (startOriginSelect == fat_pkg::ORIG_HOST);
  wire originLink = (startOriginSelect == fat_pkg::ORIG_LINK);
  wire originWired = (startOriginSelect == fat_pkg::ORIG_WIRED);
  wire selStart = (originHost && hostFireCmd) || (originLink && linkIo.startPulse)
    || (originWired && wiredIo.startPulse);
  wire selEnd = (originLink && linkIo.endPulse) || (originWired && wiredIo.endPulse);
  wire kindOk = (triggerKindSelect == fat_pkg::KIND_EXPOSURE_START);
  wire extTrig = startGateSelect && kindOk && selStart;
  // Free-run period, never shorter than the least frame period
  wire [W-1:0] effPeriod = (freeRunPeriodValue > minFramePeriodValue) ? freeRunPeriodValue
    : minFramePeriodValue;
  wire freeRunFire = !startGateSelect && kindOk && (sinceStart_r >= effPeriod);
  wire inWait = (state_r == fat_pkg::ST_WAIT);
  // A disarm caught on the last readout cycle blocks the next wait cycle too
  wire accept = armed_r && !disarmPend_r && inWait && (extTrig || freeRunFire);
  wire discard = extTrig && !accept;
  // Pulse-length style only for link or wired origins; host forces preset
  wire pulseSel = startGateSelect && !originHost
    && (shutterTimingStyle == fat_pkg::STYLE_PULSE);
  wire [W-1:0] durClamp = (shutterDurationValue == fat_pkg::CNT_ZERO) ? fat_pkg::CNT_ONE
    : shutterDurationValue;
  wire expEnd = pulseMode_r ? selEnd : (phaseCnt_r == fat_pkg::CNT_ONE);
  wire readEnd = (phaseCnt_r == fat_pkg::CNT_ONE);

  // ----------------------------------------------------------------
  // Frame sequencer next state
  // ----------------------------------------------------------------
  always_comb
  begin
    stateNxt = state_r;
    phaseCntNxt = phaseCnt_r;
    unique case (state_r)
      fat_pkg::ST_WAIT:
      begin
        if (accept)
        begin
          stateNxt = fat_pkg::ST_EXPOSE;
          phaseCntNxt = durClamp;
        end
      end
      fat_pkg::ST_EXPOSE:
      begin
        phaseCntNxt = phaseCnt_r - fat_pkg::CNT_ONE;
        if (expEnd)
        begin
          stateNxt = fat_pkg::ST_READOUT;
          phaseCntNxt = fat_pkg::READOUT_CYCLES;
        end
      end
      fat_pkg::ST_READOUT:
      begin
        phaseCntNxt = phaseCnt_r - fat_pkg::CNT_ONE;
        if (readEnd)
          stateNxt = fat_pkg::ST_WAIT;
      end
      default:
      begin
        stateNxt = fat_pkg::ST_WAIT;
        phaseCntNxt = fat_pkg::CNT_ZERO;
      end
    endcase
  end

  // Arm state: persistent arm, deferred disarm during a frame
  always_comb
  begin
    armedNxt = armed_r;
    disarmPendNxt = disarmPend_r;
    if (captureArmCmd)
    begin
      armedNxt = 1'b1;
      disarmPendNxt = 1'b0;
    end
    else if (captureDisarmCmd && inWait && !accept)
    begin
      armedNxt = 1'b0;
      disarmPendNxt = 1'b0;
    end
    else if (captureDisarmCmd && armed_r)
      disarmPendNxt = 1'b1;
    else if (disarmPend_r && (state_r == fat_pkg::ST_READOUT) && readEnd)
    begin
      armedNxt = 1'b0;
      disarmPendNxt = 1'b0;
    end
    else if (disarmPend_r && inWait)
    begin
      armedNxt = 1'b0;
      disarmPendNxt = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Sequencer and arm flags
  always_ff @(posedge clk or negedge rstSync_r)
  begin
    if (!rstSync_r)
    begin
      state_r <= fat_pkg::ST_WAIT;
      phaseCnt_r <= fat_pkg::CNT_ZERO;
      armed_r <= 1'b0;
      disarmPend_r <= 1'b0;
    end
    else
    begin
      state_r <= stateNxt;
      phaseCnt_r <= phaseCntNxt;
      armed_r <= armedNxt;
      disarmPend_r <= disarmPendNxt;
    end
  end

  // Per-frame latches and frame-period counter
  always_ff @(posedge clk or negedge rstSync_r)
  begin
    if (!rstSync_r)
    begin
      pulseMode_r <= 1'b0;
      durLatch_r <= fat_pkg::CNT_ONE;
      sinceStart_r <= fat_pkg::CNT_MAX;
    end
    else
    begin
      if (accept)
      begin
        pulseMode_r <= pulseSel;
        durLatch_r <= durClamp;
      end
      // A fresh arm lets free run fire at once
      sinceStart_r <= accept ? fat_pkg::CNT_ONE
        : (captureArmCmd && !armed_r) ? fat_pkg::CNT_MAX
        : (sinceStart_r == fat_pkg::CNT_MAX) ? sinceStart_r : sinceStart_r + fat_pkg::CNT_ONE;
    end
  end

  // Status outputs straight from flops
  always_ff @(posedge clk or negedge rstSync_r)
  begin
    if (!rstSync_r)
    begin
      waitOut_r <= 1'b0;
      exposeOut_r <= 1'b0;
      readOut_r <= 1'b0;
      startOut_r <= 1'b0;
      doneOut_r <= 1'b0;
      discardOut_r <= 1'b0;
    end
    else
    begin
      waitOut_r <= armedNxt && !disarmPendNxt && (stateNxt == fat_pkg::ST_WAIT);
      exposeOut_r <= (stateNxt == fat_pkg::ST_EXPOSE);
      readOut_r <= (stateNxt == fat_pkg::ST_READOUT);
      startOut_r <= accept;
      doneOut_r <= (state_r == fat_pkg::ST_READOUT) && readEnd;
      discardOut_r <= discard;
    end
  end

  assign captureArmed = armed_r;
  assign waitingForTrigger = waitOut_r;
  assign exposureActive = exposeOut_r;
  assign readoutActive = readOut_r;
  assign frameStart = startOut_r;
  assign frameDone = doneOut_r;
  assign triggerDiscard = discardOut_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Exposure length helper
  always_ff @(posedge clk or negedge rstSync_r)
  begin
    if (!rstSync_r)
      expLen_r <= fat_pkg::CNT_ZERO;
    else if (state_r != fat_pkg::ST_EXPOSE)
      expLen_r <= fat_pkg::CNT_ZERO;
    else
      expLen_r <= expLen_r + fat_pkg::CNT_ONE;
  end

  property p_startNeedsArm;
    @(posedge clk) disable iff (!rstSync_r)
    frameStart |-> $past(armed_r) && $past(state_r == fat_pkg::ST_WAIT);
  endproperty
  a_startNeedsArm: assert property (p_startNeedsArm) else $error("frame started while disarmed");

  property p_disarmIdle;
    @(posedge clk) disable iff (!rstSync_r)
    captureDisarmCmd && !captureArmCmd && inWait && !accept |=> !captureArmed;
  endproperty
  a_disarmIdle: assert property (p_disarmIdle) else $error("idle disarm not immediate");

  property p_disarmBusy;
    @(posedge clk) disable iff (!rstSync_r)
    captureDisarmCmd && !captureArmCmd && armed_r && !inWait |=> captureArmed && disarmPend_r;
  endproperty
  a_disarmBusy: assert property (p_disarmBusy) else $error("disarm cut a frame short");

  property p_acceptExposes;
    @(posedge clk) disable iff (!rstSync_r)
    accept |=> exposureActive && !waitingForTrigger ##0 frameStart;
  endproperty
  a_acceptExposes: assert property (p_acceptExposes) else $error("trigger did not start exposure");

  property p_gatedOff;
    @(posedge clk) disable iff (!rstSync_r)
    $rose(exposureActive) && !$past(startGateSelect) |-> $past(sinceStart_r) >= $past(minFramePeriodValue);
  endproperty
  a_gatedOff: assert property (p_gatedOff) else $error("free-run faster than allowed");

  property p_discardBusy;
    @(posedge clk) disable iff (!rstSync_r)
    extTrig && !inWait |=> triggerDiscard && !frameStart;
  endproperty
  a_discardBusy: assert property (p_discardBusy) else $error("busy trigger not discarded");

  property p_presetLength;
    @(posedge clk) disable iff (!rstSync_r)
    (state_r == fat_pkg::ST_EXPOSE) && expEnd && !pulseMode_r |-> expLen_r + fat_pkg::CNT_ONE == durLatch_r;
  endproperty
  a_presetLength: assert property (p_presetLength) else $error("preset exposure length wrong");

  property p_pulseEnd;
    @(posedge clk) disable iff (!rstSync_r)
    (state_r == fat_pkg::ST_EXPOSE) && pulseMode_r && selEnd |=> readoutActive ##1 !exposureActive;
  endproperty
  a_pulseEnd: assert property (p_pulseEnd) else $error("pulse exposure did not end on edge");

  property p_hostPreset;
    @(posedge clk) disable iff (!rstSync_r)
    accept && originHost |=> !pulseMode_r;
  endproperty
  a_hostPreset: assert property (p_hostPreset) else $error("host trigger used pulse style");

  c_freeRun: cover property (@(posedge clk) disable iff (!rstSync_r)
    accept && !startGateSelect);
  c_wiredPulse: cover property (@(posedge clk) disable iff (!rstSync_r)
    accept && originWired && pulseSel);
  c_deferredDisarm: cover property (@(posedge clk) disable iff (!rstSync_r)
    disarmPend_r && (state_r == fat_pkg::ST_READOUT) && readEnd);
  c_discard: cover property (@(posedge clk) disable iff (!rstSync_r) triggerDiscard);
endmodule : fat_trigger_ctrl
`default_nettype wire

// ---- bench/fat_trig_src.sv ----
// Far-side trigger source model driving the link and wired trigger pins
`timescale 1ns/1ps
`default_nettype none
module fat_trig_src #(
  parameter int GAP_CYC = 8
) (
  input wire logic clk,
  input wire logic activeHigh,
  output logic linkPin,
  output logic wiredPin
);
  // ----------------------------------------------------------------
  // Pin levels
  // ----------------------------------------------------------------
  logic linkAct = 1'b0;
  logic wiredAct = 1'b0;

  // Idle pins rest at the inactive level of the chosen polarity
  assign linkPin = linkAct ? activeHigh : ~activeHigh;
  assign wiredPin = wiredAct ? activeHigh : ~activeHigh;

  // ----------------------------------------------------------------
  // Pulse generator
  // ----------------------------------------------------------------
  // One active pulse of cyc cycles, changed only at falling edges
  task automatic pinPulse(input bit wired, input int cyc);
    @(negedge clk);
    if (wired) wiredAct = 1'b1; else linkAct = 1'b1;
    repeat (cyc) @(negedge clk);
    if (wired) wiredAct = 1'b0; else linkAct = 1'b0;
    repeat (GAP_CYC) @(negedge clk); // Least spacing between pulses
  endtask : pinPulse
endmodule : fat_trig_src
`default_nettype wire

// ---- bench/fat_trigger_ctrl_tb.sv ----
// Self-checking testbench for the acquisition trigger controller
`timescale 1ns/1ps
`default_nettype none
module fat_trigger_ctrl_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic captureArmCmd = 1'b0, captureDisarmCmd = 1'b0, hostFireCmd = 1'b0;
  logic startGateSelect = 1'b1, shutterTimingStyle = 1'b0, edgePolaritySelect = 1'b1;
  logic [1:0] startOriginSelect = 2'h0, triggerKindSelect = 2'h0;
  logic [23:0] shutterDurationValue = 24'h000003;
  logic [23:0] freeRunPeriodValue = 24'h0007D0, minFramePeriodValue = 24'h000010;
  logic linkPin, wiredPin, captureArmed, waitingForTrigger, exposureActive;
  logic readoutActive, frameStart, frameDone, triggerDiscard;
  logic [31:0] expLen = 32'h0;
  int fails = 0, checked = 0, startCnt = 0, doneCnt = 0, discardCnt = 0, n, s, d;

  // Clock of 40 ns period
  always #20 clk = ~clk;

  fat_trigger_ctrl u_fat_trigger_ctrl (.clk(clk), .rst_n(rst_n),
    .captureArmCmd(captureArmCmd), .captureDisarmCmd(captureDisarmCmd),
    .hostFireCmd(hostFireCmd), .startGateSelect(startGateSelect),
    .startOriginSelect(startOriginSelect), .triggerKindSelect(triggerKindSelect),
    .shutterTimingStyle(shutterTimingStyle), .edgePolaritySelect(edgePolaritySelect),
    .shutterDurationValue(shutterDurationValue), .freeRunPeriodValue(freeRunPeriodValue),
    .minFramePeriodValue(minFramePeriodValue), .linkTriggerIn(linkPin),
    .wiredTriggerIn(wiredPin), .captureArmed(captureArmed),
    .waitingForTrigger(waitingForTrigger), .exposureActive(exposureActive),
    .readoutActive(readoutActive), .frameStart(frameStart), .frameDone(frameDone),
    .triggerDiscard(triggerDiscard));

  fat_trig_src u_fat_trig_src (.clk(clk), .activeHigh(edgePolaritySelect),
    .linkPin(linkPin), .wiredPin(wiredPin));

  // Event counters and exposure length measured from the outputs
  always @(posedge clk)
  begin
    if (frameStart === 1'b1) startCnt <= startCnt + 1;
    if (frameDone === 1'b1) doneCnt <= doneCnt + 1;
    if (triggerDiscard === 1'b1) discardCnt <= discardCnt + 1;
    if (frameStart === 1'b1) expLen <= 32'h1;
    else if (exposureActive === 1'b1) expLen <= expLen + 32'h1;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // One-cycle command pulse: 0 arm, 1 disarm, 2 host fire
  task automatic cmd(input int which);
    @(negedge clk);
    captureArmCmd = (which == 0);
    captureDisarmCmd = (which == 1);
    hostFireCmd = (which == 2);
    @(negedge clk);
    {captureArmCmd, captureDisarmCmd, hostFireCmd} = 3'h0;
  endtask : cmd

  // Bounded wait until frame starts (0) or frame ends (1) reach a count
  task automatic waitCnt(input int which, input int target, input int bound, output int k);
    k = 0;
    while (((which == 0) ? startCnt : doneCnt) < target)
    begin
      @(negedge clk);
      k++;
      if (k > bound)
      begin
        fails++;
        $display("[ERR] %0t wait ran out", $time);
        print_verdict();
      end
    end
  endtask : waitCnt

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_hostFrames();
    cmd(2);
    repeat (8) @(negedge clk);
    check(startCnt, 0);
    shutterTimingStyle = 1'b0; // Host origin runs preset exposure
    cmd(0);
    check(captureArmed, 1);
    check(waitingForTrigger, 1);
    cmd(2);
    waitCnt(0, 1, 4, n);
    check(waitingForTrigger, 0);
    check(exposureActive, 1);
    cmd(2);
    check(readoutActive, 1);
    waitCnt(1, 1, 1100, n);
    check(expLen, 32'h3);
    check(startCnt, 1);
    @(negedge clk);
    check(waitingForTrigger, 1);
    cmd(2);
    waitCnt(1, 2, 1100, n);
    check(startCnt, 2);
  endtask : t_hostFrames

  task automatic t_disarm();
    cmd(1);
    check(captureArmed, 0);
    cmd(2);
    repeat (10) @(negedge clk);
    check(startCnt, 2);
    cmd(0);
    cmd(2);
    waitCnt(0, 3, 8, n);
    cmd(1);
    check(captureArmed, 1);
    waitCnt(1, 3, 1100, n);
    check(captureArmed, 0);
  endtask : t_disarm

  task automatic t_link(input logic pol);
    edgePolaritySelect = pol;
    startOriginSelect = 2'h1;
    repeat (10) @(negedge clk);
    s = startCnt;
    d = discardCnt;
    cmd(0);
    u_fat_trig_src.pinPulse(1'b0, 10);
    check(startCnt, s + 1);
    u_fat_trig_src.pinPulse(1'b0, 10);
    waitCnt(1, s + 1, 1100, n);
    check(discardCnt, d + 1);
    check(startCnt, s + 1);
    cmd(1);
  endtask : t_link

  task automatic t_pulseWidth();
    shutterTimingStyle = 1'b1;
    edgePolaritySelect = 1'b1;
    repeat (4) @(negedge clk);
    cmd(0);
    u_fat_trig_src.pinPulse(1'b0, 50);
    waitCnt(1, startCnt, 1100, n);
    check(expLen, 32'h32);
    shutterTimingStyle = 1'b0;
    cmd(1);
  endtask : t_pulseWidth

  task automatic t_wired();
    startOriginSelect = 2'h2;
    cmd(0);
    s = startCnt;
    u_fat_trig_src.pinPulse(1'b1, 20);
    repeat (60) @(negedge clk);
    check(startCnt, s);
    u_fat_trig_src.pinPulse(1'b1, 30);
    waitCnt(0, s + 1, 60, n);
    check(startCnt, s + 1);
    waitCnt(1, startCnt, 1100, n);
    cmd(1);
  endtask : t_wired

  task automatic t_blocked();
    startOriginSelect = 2'h0;
    triggerKindSelect = 2'h1;
    s = startCnt;
    cmd(0);
    cmd(2);
    repeat (8) @(negedge clk);
    check(startCnt, s);
    triggerKindSelect = 2'h0;
    startOriginSelect = 2'h3;
    cmd(2);
    repeat (8) @(negedge clk);
    check(startCnt, s);
    startOriginSelect = 2'h0;
    cmd(1);
  endtask : t_blocked

  task automatic t_freeRun();
    startGateSelect = 1'b0;
    s = startCnt;
    cmd(0);
    waitCnt(0, s + 1, 10, n);
    waitCnt(0, s + 2, 3000, n);
    check(n, 32'h000007D0);
    freeRunPeriodValue = 24'h0004B0;
    minFramePeriodValue = 24'h000708;
    waitCnt(0, s + 3, 3000, n);
    waitCnt(0, s + 4, 3000, n);
    check(n, 32'h00000708);
    cmd(1);
    waitCnt(1, startCnt, 3000, n);
    startGateSelect = 1'b1;
  endtask : t_freeRun

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    check(captureArmed, 0);
    t_hostFrames();
    t_disarm();
    t_link(1'b1);
    t_link(1'b0);
    t_pulseWidth();
    t_wired();
    t_blocked();
    t_freeRun();
    print_verdict();
  end
endmodule : fat_trigger_ctrl_tb
`default_nettype wire
